// *** cmd_divider.sv ***
`timescale 1ns/10ps
module cmd_divider
    import cmd_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // Source clock sampled as a level, and ratio minus one
    input  wire logic         src_in,
    input  wire logic [W-1:0] ratio_m1_in,
    // Divided clock level
    output logic              div_out
);

    logic         src_prev_q;
    logic [W-1:0] half_cnt_q;
    logic         src_edge;

    assign src_edge = src_in != src_prev_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_in;
        end
    end

    // Output toggles every ratio half periods of the source
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            half_cnt_q <= '0;
            div_out    <= 1'b0;
        end else if (src_edge) begin
            if (half_cnt_q >= ratio_m1_in) begin
                half_cnt_q <= '0;
                div_out    <= ~div_out;
            end else begin
                half_cnt_q <= half_cnt_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    div_hold_a: assert property (!src_edge |=> $stable(div_out))
        else $error("divided clock moved without a source edge");
    div_one_a: assert property (
        (ratio_m1_in == '0 && src_edge) |=> div_out != $past(div_out))
        else $error("ratio one did not follow every source edge");

endmodule

// *** cmd_osc_model.sv ***
`timescale 1ns/10ps
module cmd_osc_model (
    // Half period in ns; zero stops the oscillator
    input  var real  half_ns_in,
    // Oscillator pin
    output logic     osc_out
);
    // ------------------------------------------------------------------
    // Free-running oscillator
    // ------------------------------------------------------------------
    // A stopped crystal holds its last level
    initial begin
        osc_out = 1'b0;
        // Phase offset keeps pin edges off the sampling clock edges
        #1.3;
        forever begin
            if (half_ns_in > 0.0) begin
                // Steady period, no modulation peaks
                #(half_ns_in);
                osc_out = ~osc_out;
            end else begin
                #10;
            end
        end
    end
endmodule

// *** cmd_pkg.sv ***
package cmd_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 8;
    localparam int MON_WINDOW_NS      = 2000;
    localparam int MON_WINDOW_CYCLES  = MON_WINDOW_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Frequency limits, in MHz, and as edges per monitor window
    // ------------------------------------------------------------------
    localparam int OSC_LOW_MHZ        = 3;
    localparam int OSC_HIGH_MHZ       = 35;
    localparam int FLASH_NOPIPE_MHZ   = 36;
    localparam int LOW_EDGES          = OSC_LOW_MHZ * MON_WINDOW_NS / 1000;
    localparam int HIGH_EDGES         = OSC_HIGH_MHZ * MON_WINDOW_NS / 1000;
    localparam int FLASH_EDGES        = FLASH_NOPIPE_MHZ * MON_WINDOW_NS / 1000;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int PDIV_LSB           = 16;
    localparam int PDIV_W             = 4;
    localparam int EPRE_LSB           = 0;
    localparam int EPRE_W             = 16;
    localparam int FRD_W              = 3;
    localparam int CNT_W              = 8;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [FRD_W-1:0] FRD_PIPE_OFF = 3'h0;
    localparam logic [CNT_W-1:0] CNT_RST      = 8'h00;

endpackage

// *** cmd_top.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Window monitor flags oscillator below or above band
// - Failure raises flag, switches to fast internal oscillator
// - Flag and limp switch persist until power-on reset
// - Provide slow and fast internal oscillator clocks
// - External clock is peripheral clock divided by N
// - Peripheral divider ratios 1 to 16 from control
// - Flash pipeline mode; unpipelined bus clock max 36
// - Core clock runs one-to-one with bus clock
module cmd_top
    import cmd_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    // Oscillator pins
    input  wire logic        OSC_INPUT_IN,
    input  wire logic        FAST_INTERNAL_OSC_IN,
    input  wire logic        SLOW_INTERNAL_OSC_IN,
    // Control words
    input  wire logic [31:0] CLOCK_CONTROL_REG_IN,
    input  wire logic [31:0] EXT_CLOCK_PRESCALE_CTRL_IN,
    input  wire logic [2:0]  FLASH_READ_CTRL_IN,
    // Derived clocks
    output logic             SYS_BUS_CLOCK_OUT,
    output logic             CPU_CORE_CLOCK_OUT,
    output logic             PRIMARY_PERIPH_CLOCK_OUT,
    output logic             EXTERNAL_CLOCK_OUT,
    output logic             FAST_INTERNAL_OSC_OUT,
    output logic             SLOW_INTERNAL_OSC_OUT,
    // Status
    output logic             OSC_FAILURE_FLAG_OUT,
    output logic             OSC_FAIL_EVENT_OUT,
    output logic             LIMP_MODE_OUT,
    output logic             FLASH_SPEED_ERR_OUT
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] osc_sync_q;
    logic [1:0] fast_sync_q;
    logic [1:0] slow_sync_q;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            osc_sync_q  <= 2'h0;
            fast_sync_q <= 2'h0;
            slow_sync_q <= 2'h0;
        end else begin
            osc_sync_q  <= {osc_sync_q[0], OSC_INPUT_IN};
            fast_sync_q <= {fast_sync_q[0], FAST_INTERNAL_OSC_IN};
            slow_sync_q <= {slow_sync_q[0], SLOW_INTERNAL_OSC_IN};
        end
    end

    // ------------------------------------------------------------------
    // Window monitor
    // ------------------------------------------------------------------
    logic             osc_prev_q;
    logic             bus_prev_q;
    logic             osc_rise;
    logic             bus_rise;
    logic [CNT_W-1:0] win_cnt_q;
    logic [CNT_W-1:0] osc_edges_q;
    logic [CNT_W-1:0] bus_edges_q;
    logic [CNT_W-1:0] osc_edges_d;
    logic [CNT_W-1:0] bus_edges_d;
    logic             win_end;
    logic             out_of_band;

    assign osc_rise = osc_sync_q[1] && !osc_prev_q;
    assign bus_rise = SYS_BUS_CLOCK_OUT && !bus_prev_q;
    assign win_end  = win_cnt_q == CNT_W'(MON_WINDOW_CYCLES - 1);

    always_comb begin
        osc_edges_d = osc_edges_q;
        bus_edges_d = bus_edges_q;
        if (osc_rise && osc_edges_q != '1) begin
            osc_edges_d = osc_edges_q + 1'b1;
        end
        if (bus_rise && bus_edges_q != '1) begin
            bus_edges_d = bus_edges_q + 1'b1;
        end
    end

    assign out_of_band = osc_edges_d < CNT_W'(LOW_EDGES)
                      || osc_edges_d > CNT_W'(HIGH_EDGES);

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            osc_prev_q  <= 1'b0;
            bus_prev_q  <= 1'b0;
            win_cnt_q   <= CNT_RST;
            osc_edges_q <= CNT_RST;
            bus_edges_q <= CNT_RST;
        end else begin
            osc_prev_q <= osc_sync_q[1];
            bus_prev_q <= SYS_BUS_CLOCK_OUT;
            if (win_end) begin
                win_cnt_q   <= CNT_RST;
                osc_edges_q <= CNT_RST;
                bus_edges_q <= CNT_RST;
            end else begin
                win_cnt_q   <= win_cnt_q + 1'b1;
                osc_edges_q <= osc_edges_d;
                bus_edges_q <= bus_edges_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Failure flag and limp mode
    // ------------------------------------------------------------------
    logic fail_set;

    assign fail_set = win_end && out_of_band && !OSC_FAILURE_FLAG_OUT;

    // Only the power-on reset clears the flag
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            OSC_FAILURE_FLAG_OUT <= 1'b0;
            LIMP_MODE_OUT        <= 1'b0;
            OSC_FAIL_EVENT_OUT   <= 1'b0;
        end else begin
            if (fail_set) begin
                OSC_FAILURE_FLAG_OUT <= 1'b1;
                LIMP_MODE_OUT        <= 1'b1;
            end
            OSC_FAIL_EVENT_OUT <= fail_set;
        end
    end

    // ------------------------------------------------------------------
    // Clock selection and pass-through
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            SYS_BUS_CLOCK_OUT     <= 1'b0;
            CPU_CORE_CLOCK_OUT    <= 1'b0;
            FAST_INTERNAL_OSC_OUT <= 1'b0;
            SLOW_INTERNAL_OSC_OUT <= 1'b0;
        end else begin
            SYS_BUS_CLOCK_OUT     <= LIMP_MODE_OUT ? fast_sync_q[1] : osc_sync_q[1];
            CPU_CORE_CLOCK_OUT    <= LIMP_MODE_OUT ? fast_sync_q[1] : osc_sync_q[1];
            FAST_INTERNAL_OSC_OUT <= fast_sync_q[1];
            SLOW_INTERNAL_OSC_OUT <= slow_sync_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Flash speed check
    // ------------------------------------------------------------------
    logic pipe_off;

    assign pipe_off = FLASH_READ_CTRL_IN[FRD_W-1:0] == FRD_PIPE_OFF;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            FLASH_SPEED_ERR_OUT <= 1'b0;
        end else if (win_end) begin
            FLASH_SPEED_ERR_OUT <= pipe_off && bus_edges_d > CNT_W'(FLASH_EDGES);
        end
    end

    // ------------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------------
    cmd_divider #(
        .W (PDIV_W)
    ) u_periph_div (
        .clk_in      (CLK_IN),
        .rst_in      (RST_IN),
        .src_in      (SYS_BUS_CLOCK_OUT),
        .ratio_m1_in (CLOCK_CONTROL_REG_IN[PDIV_LSB +: PDIV_W]),
        .div_out     (PRIMARY_PERIPH_CLOCK_OUT)
    );

    cmd_divider #(
        .W (EPRE_W)
    ) u_ext_div (
        .clk_in      (CLK_IN),
        .rst_in      (RST_IN),
        .src_in      (PRIMARY_PERIPH_CLOCK_OUT),
        .ratio_m1_in (EXT_CLOCK_PRESCALE_CTRL_IN[EPRE_LSB +: EPRE_W]),
        .div_out     (EXTERNAL_CLOCK_OUT)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    fail_detect_a: assert property (
        (win_end && out_of_band) |=> OSC_FAILURE_FLAG_OUT)
        else $error("out-of-band oscillator not flagged");
    no_false_fail_a: assert property (
        (!OSC_FAILURE_FLAG_OUT && !(win_end && out_of_band)) |=> !OSC_FAILURE_FLAG_OUT)
        else $error("flag set without an out-of-band window");
    limp_follow_a: assert property (
        LIMP_MODE_OUT |=> SYS_BUS_CLOCK_OUT == $past(fast_sync_q[1]))
        else $error("limp mode not clocked by fast oscillator");
    flag_sticky_a: assert property (
        OSC_FAILURE_FLAG_OUT |=> OSC_FAILURE_FLAG_OUT && LIMP_MODE_OUT)
        else $error("failure flag or limp mode dropped");
    event_once_a: assert property (
        OSC_FAIL_EVENT_OUT |-> OSC_FAILURE_FLAG_OUT && !$past(OSC_FAILURE_FLAG_OUT) ##1
        !OSC_FAIL_EVENT_OUT [*3])
        else $error("failure event not a single pulse on set");
    core_ratio_a: assert property (
        CPU_CORE_CLOCK_OUT == SYS_BUS_CLOCK_OUT)
        else $error("core clock differs from bus clock");
    flash_err_a: assert property (
        (win_end && !pipe_off) |=> !FLASH_SPEED_ERR_OUT)
        else $error("flash speed error with pipeline enabled");
    window_len_a: assert property (
        win_end |=> win_cnt_q == CNT_RST ##1 win_cnt_q == CNT_W'(1))
        else $error("monitor window did not restart");
    slow_pass_a: assert property (
        SLOW_INTERNAL_OSC_OUT == $past(slow_sync_q[1]))
        else $error("slow oscillator not passed through");

    fail_seen_c: cover property (OSC_FAIL_EVENT_OUT);
    limp_run_c: cover property (LIMP_MODE_OUT && $rose(SYS_BUS_CLOCK_OUT));
    flash_err_c: cover property ($rose(FLASH_SPEED_ERR_OUT));
    ext_toggle_c: cover property ($rose(EXTERNAL_CLOCK_OUT));

endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
    import cmd_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk          = 1'b0;
    logic        rst          = 1'b1;
    logic        fast_osc;
    logic        slow_osc;
    logic        osc;
    real         osc_half     = 50.0;
    logic [31:0] clk_ctrl     = 32'h0;
    logic [31:0] ext_ctrl     = 32'h0;
    logic [2:0]  frd_ctrl     = 3'h1;
    logic        bus, core, per, ext, fast_o, slow_o, flag, evt, limp, ferr;
    int          n_fail       = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    int          n_evt        = 0;
    logic [3:0]  rm1 [4]      = '{4'h0, 4'h1, 4'hf, 4'h2};
    logic [15:0] nm1 [4]      = '{16'h0, 16'h2, 16'h0, 16'hffff};

    always #4 clk = ~clk;

    cmd_osc_model OSC (.half_ns_in(osc_half), .osc_out(osc));
    cmd_osc_model FAST (.half_ns_in(50.0), .osc_out(fast_osc));
    // Slow oscillator stands in for the alternate timer clock
    cmd_osc_model SLOW (.half_ns_in(6250.0), .osc_out(slow_osc));

    cmd_top DUT (
        .CLK_IN                    (clk),
        .RST_IN                    (rst),
        .OSC_INPUT_IN              (osc),
        .FAST_INTERNAL_OSC_IN      (fast_osc),
        .SLOW_INTERNAL_OSC_IN      (slow_osc),
        .CLOCK_CONTROL_REG_IN      (clk_ctrl),
        .EXT_CLOCK_PRESCALE_CTRL_IN(ext_ctrl),
        .FLASH_READ_CTRL_IN        (frd_ctrl),
        .SYS_BUS_CLOCK_OUT         (bus),
        .CPU_CORE_CLOCK_OUT        (core),
        .PRIMARY_PERIPH_CLOCK_OUT  (per),
        .EXTERNAL_CLOCK_OUT        (ext),
        .FAST_INTERNAL_OSC_OUT     (fast_o),
        .SLOW_INTERNAL_OSC_OUT     (slow_o),
        .OSC_FAILURE_FLAG_OUT      (flag),
        .OSC_FAIL_EVENT_OUT        (evt),
        .LIMP_MODE_OUT             (limp),
        .FLASH_SPEED_ERR_OUT       (ferr)
    );

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic chk_in(input int v, input int lo, input int hi, input string what);
        chk(32'(v >= lo && v <= hi), 32'h1, what);
    endtask

    // Counts rising edges of bus, peripheral, external, fast and slow outputs
    task automatic measure(input int n, output int c [5]);
        logic [4:0] cur;
        logic [4:0] prv;
        c = '{0, 0, 0, 0, 0};
        prv = {slow_o, fast_o, ext, per, bus};
        repeat (n) begin
            @(negedge clk);
            cur = {slow_o, fast_o, ext, per, bus};
            for (int i = 0; i < 5; i++) begin
                if (cur[i] === 1'b1 && prv[i] === 1'b0) begin
                    c[i]++;
                end
            end
            prv = cur;
        end
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        n_evt = 0;
        @(negedge clk);
    endtask

    task automatic wait_evt(input int lim);
        int i;
        i = 0;
        while (evt !== 1'b1 && i < lim) begin
            @(negedge clk);
            i++;
        end
    endtask

    // ------------------------------------------------------------------
    // Watchdog, event counter and core clock tracking
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            summarize();
        end
    end

    always @(negedge clk) begin
        if (!rst) begin
            if (evt === 1'b1) begin
                n_evt++;
            end
            chk(32'(core), 32'(bus), "core clock");
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        int c [5];
        int d;
        do_reset();
        chk(32'({flag, limp, evt, bus, per, ext, ferr}), 32'h0, "after reset");
        measure(750, c);
        chk(32'({flag, limp}), 32'h0, "in-band flag");
        // Peripheral and external clocks match bus edges divided by their ratios in each of four settings
        for (int k = 0; k < 4; k++) begin
            clk_ctrl = {12'h0, rm1[k], 16'h0};
            ext_ctrl = {16'h0, nm1[k]};
            repeat (200) @(negedge clk);
            measure(2000, c);
            chk_in(c[0], 158, 162, "bus from oscillator");
            d = int'(rm1[k]) + 1;
            chk_in(c[1], c[0] / d - 1, c[0] / d + 1, "peripheral ratio");
            d = d * (int'(nm1[k]) + 1);
            chk_in(c[2], c[0] / d - 1, c[0] / d + 1, "external prescale");
        end
        measure(3200, c);
        chk_in(c[3], 254, 258, "fast internal osc");
        chk_in(c[4], 1, 3, "slow internal osc");
        $display("test in-band dividers done");

        osc_half = 0.0;
        wait_evt(520);
        chk(32'(evt), 32'h1, "event on low failure");
        chk(32'({flag, limp}), 32'h3, "flag and limp");
        @(negedge clk);
        chk(32'(evt), 32'h0, "event one cycle");
        osc_half = 100.0;
        measure(750, c);
        chk(32'({flag, limp}), 32'h3, "sticky flag");
        chk(32'(n_evt), 32'h1, "single event");
        chk_in(c[0], 58, 62, "bus from fast osc");
        chk(32'(ferr), 32'h0, "pipelined flash");
        $display("test low failure done");

        do_reset();
        measure(750, c);
        chk(32'({flag, limp}), 32'h0, "cleared by reset");
        chk_in(c[0], 29, 31, "bus back on oscillator");
        $display("test reset recovery done");

        frd_ctrl = 3'h0;
        // Source at 40 MHz, above the oscillator band and the unpipelined flash limit
        osc_half = 12.5;
        wait_evt(520);
        chk(32'({evt, flag, limp}), 32'h7, "high failure");
        repeat (2) @(negedge clk);
        chk(32'(ferr), 32'h1, "flash too fast");
        repeat (300) @(negedge clk);
        chk(32'(ferr), 32'h0, "flash within limit");
        $display("test high failure done");
        summarize();
    end
endmodule
